// *** oag_code_mem.sv ***
// Program memory model answering table fetches
`timescale 1ns/1ps
module oag_code_mem (
	input wire logic clk,
	input wire logic code_rd,
	input wire logic [15:0] code_addr,
	output logic [7:0] code_data
);
	// ==========
	// Byte is a fixed mix of the address; valid in the cycle after the strobe
	initial code_data = 8'h00;
	always @(posedge clk)
	begin
		if (code_rd)
			code_data <= code_addr[7:0] ^ code_addr[15:8] ^ 8'hA5;
		else
			code_data <= ~code_data; // Idle bus inverts its byte every clock, so the last fetched byte returns on alternate cycles
	end
endmodule

// *** oag_pkg.sv ***
// Constants, modes and register map of the operand address generator
package oag_pkg;
	// ==========================================================
	// Bus and register map
	localparam int AW = 11;
	localparam logic [10:0] OFS_PSW = 11'h000;
	localparam logic [10:0] OFS_ACC = 11'h004;
	localparam logic [10:0] OFS_MUL = 11'h008;
	localparam logic [10:0] OFS_DP0 = 11'h00C;
	localparam logic [10:0] OFS_DP1 = 11'h010;
	localparam logic [10:0] OFS_PSEL = 11'h014;
	localparam logic [10:0] OFS_SP = 11'h018;
	localparam logic [10:0] OFS_PAGE = 11'h01C;
	localparam logic [10:0] OFS_PC = 11'h020;
	localparam logic [10:0] OFS_INSTR = 11'h024;
	localparam logic [10:0] OFS_STAT = 11'h028;
	localparam logic [10:0] OFS_RES = 11'h02C;
	localparam int RAM_WIN_BIT = 10;
	// ==========================================================
	// Field positions
	localparam int PSW_CY = 7;
	localparam int PSW_BSH = 4;
	localparam int PSW_BSL = 3;
	localparam int INS_B1 = 8;
	localparam int INS_B2 = 16;
	localparam int INS_MODE = 24;
	localparam int INS_LEN = 28;
	localparam int RES_SFR = 16;
	localparam int RES_BIT = 17;
	localparam int RES_DATA = 24;
	// ==========================================================
	// Reset values and address constants
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] LOW_LIMIT = 8'h80;
	localparam logic [7:0] BIT_BASE = 8'h20;
	localparam logic [1:0] LEN_LONG = 2'h3;
	// ==========================================================
	// Addressing modes carried in the instruction word
	typedef enum logic [3:0] {
		M_REG = 4'h0, M_DIR = 4'h1, M_BIT = 4'h2, M_IND = 4'h3,
		M_PUSH = 4'h4, M_POP = 4'h5, M_XRI = 4'h6, M_XDP = 4'h7,
		M_IMM = 4'h8, M_TPC = 4'h9, M_TDP = 4'hA, M_REL = 4'hB,
		M_ABS = 4'hC, M_LONG = 4'hD, M_SPC = 4'hE, M_NOP = 4'hF
	} oag_mode_t;
	// Idle until a start, then machine cycle phases C1 to C4, one clock each
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001, ST_C1 = 5'b00010, ST_C2 = 5'b00100,
		ST_C3 = 5'b01000, ST_C4 = 5'b10000
	} oag_state_t;
endpackage

// *** oag_ram.sv ***
// Scratchpad memory with registered read data
`timescale 1ns/1ps
module oag_ram #(
	parameter int DW = 8,
	parameter int AWD = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AWD-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	// ==========================================================
	// Storage
	logic [DW-1:0] mem [0:(1<<AWD)-1]; // Byte array

	// Refuse shapes the core cannot use
	if (DW != 8 || AWD != 8)
	begin : g_chk
		$error("oag_ram supports only 256 x 8");
	end

	// Write and registered read of the same address; the read returns the byte held before the write
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// *** oag_sva.sv ***
// Checker for bus handshake, fetch strobes and machine cycle timing
`timescale 1ns/1ps
module oag_sva (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [15:0] code_addr,
	input wire logic code_rd,
	input wire logic [15:0] xdata_addr,
	input wire logic xdata_en
);
	// ==========
	// One domain, one reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========
	// Strobes and handshake
	AST_FETCH_GAP: assert property (code_rd |=> !code_rd [*3])
		else $error("table fetch strobes closer than one machine cycle");
	AST_XMOVE_GAP: assert property (xdata_en |=> !xdata_en [*3])
		else $error("external move strobes closer than one machine cycle");
	AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_ANSWER_REQ: assert property (!avs_waitrequest |-> (avs_read || avs_write))
		else $error("answer given with no request pending");
	AST_ANSWER_MIN: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 avs_waitrequest) else $error("answer came too early");
	AST_ANSWER_MAX: assert property ($rose(avs_read || avs_write) |->
		##[2:8] !avs_waitrequest) else $error("answer came too late");
	AST_FETCH_ADDR: assert property ($changed(code_addr) |-> ##[0:1] code_rd)
		else $error("program address moved without a fetch");
	AST_XMOVE_ADDR: assert property ($changed(xdata_addr) |-> ##[0:1] xdata_en)
		else $error("external address moved without a move strobe");
	AST_NO_OVERLAP: assert property (code_rd |-> avs_waitrequest && !xdata_en)
		else $error("fetch overlaps a bus answer or external move");
	AST_RESET_IDLE: assert property (disable iff (1'b0)
		sys_rst |=> avs_waitrequest && !code_rd && !xdata_en)
		else $error("outputs not idle under reset");
endmodule
bind oag_top oag_sva u_sva (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .code_addr(code_addr),
	.code_rd(code_rd), .xdata_addr(xdata_addr), .xdata_en(xdata_en));

// *** oag_target.sv ***
// Branch target arithmetic for relative, page and far jumps
`timescale 1ns/1ps
module oag_target (
	input wire logic [15:0] pc,
	input wire oag_pkg::oag_mode_t mode,
	input wire logic [7:0] opcode,
	input wire logic [7:0] b1,
	input wire logic [7:0] b2,
	input wire logic [1:0] len,
	output logic [15:0] target
);
	import oag_pkg::*;
	// ==========================================================
	// Address arithmetic
	logic [15:0] next_pc; // Address after the branch
	logic [7:0] rel_off; // Offset is the last instruction byte
	logic [15:0] rel_tgt; // Relative target
	logic [15:0] abs_tgt; // Page target
	logic [15:0] far_tgt; // Far target

	assign next_pc = pc + {14'h0, len};
	assign rel_off = (len == LEN_LONG) ? b2 : b1;
	assign rel_tgt = next_pc + {{8{rel_off[7]}}, rel_off};
	assign abs_tgt = {next_pc[15:11], opcode[7:5], b1};
	assign far_tgt = {b1, b2};
	// Pick by mode, relative otherwise
	assign target = (mode == M_ABS) ? abs_tgt : (mode == M_LONG) ? far_tgt : rel_tgt;
endmodule

// *** oag_top.sv ***
// Operand and branch address generator with register bus
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module oag_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [oag_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [15:0] code_addr,
	output logic code_rd,
	input wire logic [7:0] code_data,
	output logic [15:0] xdata_addr,
	output logic xdata_en
);
	import oag_pkg::*;

	// ==========================================================
	// Architectural registers
	logic [7:0] psw_ff; // Status word
	logic [7:0] acc_ff; // Accumulator
	logic [7:0] mul_ff; // Multiply register
	logic [15:0] dp0_ff; // Data pointer zero
	logic [15:0] dp1_ff; // Data pointer one
	logic psel_ff; // Pointer select bit
	logic [7:0] sp_ff; // Stack pointer
	logic [7:0] page_ff; // Upper page latch
	logic [15:0] pc_ff; // Program counter
	logic [31:0] ins_ff; // Instruction word
	oag_state_t st_ff; // Machine cycle phase
	logic [7:0] eaddr_ff; // Effective scratchpad address
	logic [15:0] res_addr_ff; // Resulting address
	logic [7:0] res_data_ff; // Resulting operand
	logic res_sfr_ff; // Result names a function register
	logic [2:0] res_bit_ff; // Bit position for bit mode
	logic done_ff; // Operation finished
	logic [15:0] code_addr_ff; // Program memory address
	logic code_rd_ff; // Program memory read strobe
	logic [15:0] xd_addr_ff; // External data address
	logic xd_en_ff; // External data strobe
	logic bsy_ff; // Bus access in progress
	logic wait_ff; // Waitrequest
	logic [31:0] rdata_ff; // Read data

	// ==========================================================
	// Functions
	// Base plus unsigned byte
	function automatic logic [15:0] add16(input logic [15:0] base, input logic [7:0] off);
		add16 = base + {8'h00, off};
	endfunction

	// Register decode of a bus address
	function automatic logic hit(input logic [10:0] a, input logic [10:0] ofs);
		hit = (a == ofs);
	endfunction

	// ==========================================================
	// Instruction fields
	oag_mode_t mode; // Addressing mode
	logic [7:0] op; // Opcode
	logic [7:0] b1; // First operand byte
	logic [7:0] b2; // Second operand byte
	logic [1:0] len; // Instruction length
	logic [1:0] bank; // Active bank
	logic [15:0] sel_dp; // Selected data pointer

	assign mode = oag_mode_t'(ins_ff[INS_MODE+3:INS_MODE]);
	assign op = ins_ff[7:0];
	assign b1 = ins_ff[INS_B1+7:INS_B1];
	assign b2 = ins_ff[INS_B2+7:INS_B2];
	assign len = ins_ff[INS_LEN+1:INS_LEN];
	assign bank = {psw_ff[PSW_BSH], psw_ff[PSW_BSL]};
	assign sel_dp = psel_ff ? dp1_ff : dp0_ff;

	// ==========================================================
	// Phase decode
	logic st_idle, st_c1, st_c2, st_c3, st_c4;
	assign st_idle = (st_ff == ST_IDLE);
	assign st_c1 = (st_ff == ST_C1);
	assign st_c2 = (st_ff == ST_C2);
	assign st_c3 = (st_ff == ST_C3);
	assign st_c4 = (st_ff == ST_C4);

	// ==========================================================
	// Scratchpad address forming
	logic [7:0] wreg_addr; // Working register byte
	logic [7:0] ptr_addr; // Pointer register 0 or 1
	logic [7:0] bit_byte; // Byte holding an addressed bit
	logic [7:0] sp_inc; // Stack pointer plus one
	logic [7:0] sp_dec; // Stack pointer minus one
	logic [7:0] first_addr; // Address used in the first phases
	logic ind_mode; // Mode reads a pointer register first
	logic low_dir; // Direct byte lies in the scratchpad

	assign wreg_addr = {3'b000, bank, op[2:0]};
	assign ptr_addr = {3'b000, bank, 2'b00, op[0]};
	// Low bit space lives in bytes 20-2F, above that the bit address with its low three bits cleared
	assign bit_byte = b1[7] ? {b1[7:3], 3'b000} : (BIT_BASE + {4'h0, b1[6:3]});
	assign sp_inc = sp_ff + 8'h01;
	assign sp_dec = sp_ff - 8'h01;
	assign ind_mode = (mode == M_IND) || (mode == M_XRI);
	assign low_dir = (b1 < LOW_LIMIT);
	// First address by mode
	assign first_addr = (mode == M_REG) ? wreg_addr :
		(mode == M_BIT) ? bit_byte :
		ind_mode ? ptr_addr :
		(mode == M_PUSH) ? sp_inc :
		(mode == M_POP) ? sp_ff : b1;

	// ==========================================================
	// Branch targets
	logic [15:0] target; // Jump destination
	logic is_branch; // Mode moves the program counter

	oag_target u_target (
		.pc(pc_ff),
		.mode(mode),
		.opcode(op),
		.b1(b1),
		.b2(b2),
		.len(len),
		.target(target)
	);
	assign is_branch = (mode == M_REL) || (mode == M_ABS) || (mode == M_LONG);

	// ==========================================================
	// Bus slave decode
	logic ram_win; // Access falls in the scratchpad window
	logic bus_go; // Accept a new request
	logic wcommit; // Write takes effect
	logic [31:0] rd_mux; // Read data before registering
	logic start; // Instruction write launches a cycle

	assign ram_win = avs_address[RAM_WIN_BIT];
	// Start only while the engine sleeps so the memory port is free
	assign bus_go = (avs_read || avs_write) && wait_ff && !bsy_ff && st_idle;
	assign wcommit = avs_write && !wait_ff;
	assign start = wcommit && hit(avs_address, OFS_INSTR);

	// ==========================================================
	// Scratchpad port
	logic ram_we; // Memory write
	logic [7:0] ram_addr; // Memory address
	logic [7:0] ram_wd; // Memory write data
	logic [7:0] ram_q; // Memory read data

	// Engine owns the port outside idle, the bus otherwise
	assign ram_addr = !st_idle ? (st_c3 ? eaddr_ff : first_addr) : avs_address[9:2];
	assign ram_we = (st_c3 && (mode == M_PUSH)) || (wcommit && ram_win);
	assign ram_wd = st_c3 ? b1 : avs_writedata[7:0];

	oag_ram #(.DW(8), .AWD(8)) u_ram (
		.clk(clk),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wd),
		.rdata(ram_q)
	);

	// Register read selection
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (ram_win)
		begin
			rd_mux = {24'h000000, ram_q};
		end
		else
		begin
			case (avs_address)
				OFS_PSW: rd_mux = {24'h000000, psw_ff};
				OFS_ACC: rd_mux = {24'h000000, acc_ff};
				OFS_MUL: rd_mux = {24'h000000, mul_ff};
				OFS_DP0: rd_mux = {16'h0000, dp0_ff};
				OFS_DP1: rd_mux = {16'h0000, dp1_ff};
				OFS_PSEL: rd_mux = {31'h0, psel_ff};
				OFS_SP: rd_mux = {24'h000000, sp_ff};
				OFS_PAGE: rd_mux = {24'h000000, page_ff};
				OFS_PC: rd_mux = {16'h0000, pc_ff};
				OFS_INSTR: rd_mux = ins_ff;
				OFS_STAT: rd_mux = {30'h0, done_ff, !st_idle};
				OFS_RES: rd_mux = {res_data_ff, 4'h0, res_bit_ff, res_sfr_ff, res_addr_ff};
				default: rd_mux = 32'h00000000; // Unmapped reads zero
			endcase
		end
	end

	// ==========================================================
	// Next values of architectural registers
	logic [7:0] nxt_acc, nxt_sp;
	logic [15:0] nxt_pc;
	logic [7:0] spc_data; // Register-named operand value
	logic [15:0] tbl_addr; // Table read address

	assign tbl_addr = (mode == M_TPC) ? add16(pc_ff, acc_ff) : add16(sel_dp, acc_ff);
	// Table byte replaces the index in the accumulator
	assign nxt_acc = (wcommit && hit(avs_address, OFS_ACC)) ? avs_writedata[7:0] :
		(st_c4 && (mode == M_TPC || mode == M_TDP)) ? code_data : acc_ff;
	// Push grows before its write, pop shrinks after its read
	assign nxt_sp = (wcommit && hit(avs_address, OFS_SP)) ? avs_writedata[7:0] :
		(st_c2 && (mode == M_PUSH)) ? sp_inc :
		(st_c4 && (mode == M_POP)) ? sp_dec : sp_ff;
	assign nxt_pc = (wcommit && hit(avs_address, OFS_PC)) ? avs_writedata[15:0] :
		(st_c4 && is_branch) ? target : pc_ff;
	// Accumulator, multiply, carry or selected pointer low byte
	assign spc_data = (op[1:0] == 2'h0) ? acc_ff : (op[1:0] == 2'h1) ? mul_ff :
		(op[1:0] == 2'h2) ? {7'h00, psw_ff[PSW_CY]} : sel_dp[7:0];

	// ==========================================================
	// Machine cycle sequencer: four phases, one fetch
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_ff <= ST_IDLE;
		end
		else
		begin
			case (st_ff)
				ST_IDLE: st_ff <= start ? ST_C1 : ST_IDLE;
				ST_C1: st_ff <= ST_C2;
				ST_C2: st_ff <= ST_C3;
				ST_C3: st_ff <= ST_C4;
				ST_C4: st_ff <= ST_IDLE;
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// Bus handshake: wait drops one cycle after acceptance
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bsy_ff <= 1'b0;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end
		else if (bus_go)
		begin
			bsy_ff <= 1'b1;
		end
		else if (bsy_ff && wait_ff)
		begin
			wait_ff <= 1'b0;
			rdata_ff <= rd_mux;
		end
		else if (!wait_ff)
		begin
			wait_ff <= 1'b1;
			bsy_ff <= 1'b0;
		end
	end

	// Software-written registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			psw_ff <= RST_BYTE;
			mul_ff <= RST_BYTE;
			dp0_ff <= RST_WORD;
			dp1_ff <= RST_WORD;
			psel_ff <= 1'b0;
			page_ff <= RST_BYTE;
			ins_ff <= 32'h00000000;
		end
		else if (wcommit)
		begin
			psw_ff <= hit(avs_address, OFS_PSW) ? avs_writedata[7:0] : psw_ff;
			mul_ff <= hit(avs_address, OFS_MUL) ? avs_writedata[7:0] : mul_ff;
			dp0_ff <= hit(avs_address, OFS_DP0) ? avs_writedata[15:0] : dp0_ff;
			dp1_ff <= hit(avs_address, OFS_DP1) ? avs_writedata[15:0] : dp1_ff;
			psel_ff <= hit(avs_address, OFS_PSEL) ? avs_writedata[0] : psel_ff;
			page_ff <= hit(avs_address, OFS_PAGE) ? avs_writedata[7:0] : page_ff;
			ins_ff <= start ? avs_writedata : ins_ff;
		end
	end

	// Registers shared by bus and engine
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			acc_ff <= RST_BYTE;
			sp_ff <= RST_SP;
			pc_ff <= RST_WORD;
		end
		else
		begin
			acc_ff <= nxt_acc;
			sp_ff <= nxt_sp;
			pc_ff <= nxt_pc;
		end
	end

	// Effective address: in M_IND the pointer contents replace the pointer location, M_XRI keeps the location
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			eaddr_ff <= RST_BYTE;
		end
		else if (st_c2)
		begin
			eaddr_ff <= (mode == M_IND) ? ram_q : first_addr;
		end
	end

	// Program memory and external data strobes in the third phase
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			code_addr_ff <= RST_WORD;
			code_rd_ff <= 1'b0;
			xd_addr_ff <= RST_WORD;
			xd_en_ff <= 1'b0;
		end
		else
		begin
			code_rd_ff <= st_c2 && (mode == M_TPC || mode == M_TDP);
			xd_en_ff <= st_c2 && (mode == M_XRI || mode == M_XDP);
			if (st_c2 && (mode == M_TPC || mode == M_TDP))
			begin
				code_addr_ff <= tbl_addr;
			end
			if (st_c2 && mode == M_XRI)
			begin
				xd_addr_ff <= {page_ff, ram_q};
			end
			else if (st_c2 && mode == M_XDP)
			begin
				xd_addr_ff <= sel_dp;
			end
		end
	end

	// Results captured in the last phase
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			res_addr_ff <= RST_WORD;
			res_data_ff <= RST_BYTE;
			res_sfr_ff <= 1'b0;
			res_bit_ff <= 3'h0;
			done_ff <= 1'b0;
		end
		else if (start)
		begin
			done_ff <= 1'b0;
		end
		else if (st_c4)
		begin
			done_ff <= 1'b1;
			res_bit_ff <= b1[2:0];
			res_sfr_ff <= ((mode == M_DIR) && !low_dir) || ((mode == M_BIT) && b1[7]);
			case (mode)
				M_IMM: res_data_ff <= b1;
				M_SPC: res_data_ff <= spc_data;
				M_TPC, M_TDP: res_data_ff <= code_data;
				M_DIR: res_data_ff <= low_dir ? ram_q : RST_BYTE;
				default: res_data_ff <= ram_q;
			endcase
			case (mode)
				M_XRI, M_XDP: res_addr_ff <= xd_addr_ff;
				M_TPC, M_TDP: res_addr_ff <= code_addr_ff;
				M_REL, M_ABS, M_LONG: res_addr_ff <= target;
				M_SPC: res_addr_ff <= sel_dp;
				default: res_addr_ff <= {8'h00, eaddr_ff};
			endcase
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign code_addr = code_addr_ff;
	assign code_rd = code_rd_ff;
	assign xdata_addr = xd_addr_ff;
	assign xdata_en = xd_en_ff;
endmodule

// *** oag_top_tb.sv ***
// Self-checking testbench of the operand address generator
`timescale 1ns/1ps
`define CHK(g,e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module oag_top_tb;
	import oag_pkg::*;
	// ==========
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [AW-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] code_addr;
	logic code_rd;
	logic [7:0] code_data;
	logic [15:0] xdata_addr;
	logic xdata_en;
	logic [31:0] q; // Last read word
	logic [7:0] a8; // Scratch byte address
	int n_errors = 0;
	int n_tests = 0;
	int n_xmv = 0; // External move strobes seen
	int n_fetch = 0; // Table fetch strobes seen
	initial
	begin
		forever #25 clk = ~clk;
	end
	oag_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.code_addr(code_addr), .code_rd(code_rd), .code_data(code_data),
		.xdata_addr(xdata_addr), .xdata_en(xdata_en));
	oag_code_mem u_mem (.clk(clk), .code_rd(code_rd), .code_addr(code_addr),
		.code_data(code_data));
	// Count the one-cycle strobes on the far-side ports
	always @(posedge clk)
	begin
		if (xdata_en === 1'b1)
			n_xmv++;
		if (code_rd === 1'b1)
			n_fetch++;
	end
	// ==========
	// Bus and operation tasks
	function automatic logic [10:0] ra(input logic [7:0] i);
		return {1'b1, i, 2'b00};
	endfunction
	task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d);
		int k;
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= ~w;
			avs_write <= w;
			k = 0;
			do
			begin
				@(posedge clk);
				k++;
			end while (avs_waitrequest !== 1'b0 && k < 40);
			`CHK(avs_waitrequest, 1'b0)
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic run(input oag_mode_t m, input logic [7:0] op, b1, b2,
		input logic [1:0] len);
		int k;
		begin
			acc(1'b1, OFS_INSTR, {2'b00, len, m, b2, b1, op});
			k = 0;
			do
			begin
				acc(1'b0, OFS_STAT, 32'h0);
				k++;
			end while (q[1] !== 1'b1 && k < 10);
			`CHK(q[1], 1'b1)
			acc(1'b0, OFS_RES, 32'h0);
		end
	endtask
	task automatic br(input logic [15:0] pc, input oag_mode_t m, input logic [7:0] op, b1,
		b2, input logic [1:0] len, input logic [15:0] ex);
		begin
			acc(1'b1, OFS_PC, {16'h0, pc});
			run(m, op, b1, b2, len);
			acc(1'b0, OFS_PC, 32'h0);
			`CHK(q[15:0], ex)
		end
	endtask
	task results;
		begin
			$display("Compares %0d, mismatches %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// ==========
	// Hang guard, well beyond the expected run
	initial
	begin
		#(50 * 30000);
		n_errors++;
		results();
	end
	// ==========
	// Test sequence
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		acc(1'b0, OFS_SP, 32'h0);
		`CHK(q, 32'h0000_0007)
		acc(1'b0, 11'h3FC, 32'h0);
		`CHK(q, 32'h0)
		$display("reset values done");
		for (int b = 0; b < 4; b++)
		begin
			a8 = 8'(b * 6 + 7);
			acc(1'b1, ra(a8), {24'h0, a8 ^ 8'hFF});
			acc(1'b1, OFS_PSW, {27'h0, 2'(b), 3'h0});
			run(M_REG, {5'b10101, 3'(7 - 2 * b)}, 8'h0, 8'h0, 2'h0);
			`CHK(q[15:0], {8'h00, a8})
			`CHK(q[31:24], a8 ^ 8'hFF)
		end
		acc(1'b1, OFS_PSW, 32'h0);
		acc(1'b1, OFS_ACC, 32'h5A);
		run(M_SPC, 8'hE4, 8'h0, 8'h0, 2'h0);
		`CHK(q[31:24], 8'h5A)
		acc(1'b1, OFS_MUL, 32'hA6);
		run(M_SPC, 8'h01, 8'h0, 8'h0, 2'h0);
		`CHK(q[31:24], 8'hA6)
		acc(1'b1, OFS_PSW, 32'h80);
		run(M_SPC, 8'h02, 8'h0, 8'h0, 2'h0);
		`CHK(q[31:24], 8'h01)
		acc(1'b1, OFS_PSW, 32'h0);
		acc(1'b1, OFS_DP1, 32'hBEEF);
		acc(1'b1, OFS_PSEL, 32'h1);
		run(M_SPC, 8'h03, 8'h0, 8'h0, 2'h0);
		`CHK(q[15:0], 16'hBEEF)
		$display("register modes done");
		acc(1'b1, ra(8'h7F), 32'h3C);
		run(M_DIR, 8'h0, 8'h7F, 8'h0, 2'h0);
		`CHK({q[31:24], q[16]}, 9'h078)
		run(M_DIR, 8'h0, 8'h80, 8'h0, 2'h0);
		`CHK({q[16], q[15:0]}, 17'h1_0080)
		run(M_BIT, 8'h0, 8'h7F, 8'h0, 2'h0);
		`CHK({q[19:17], q[15:0]}, 19'h7_002F)
		run(M_BIT, 8'h0, 8'h00, 8'h0, 2'h0);
		`CHK({q[19:17], q[15:0]}, 19'h0_0020)
		run(M_BIT, 8'h0, 8'hD3, 8'h0, 2'h0);
		`CHK({q[19:17], q[15:0]}, 19'h3_00D0)
		acc(1'b1, ra(8'h01), 32'hC0);
		acc(1'b1, ra(8'hC0), 32'h77);
		run(M_IND, 8'h01, 8'h0, 8'h0, 2'h0);
		`CHK({q[31:24], q[16], q[15:0]}, 25'h0EE_00C0)
		$display("direct and indirect done");
		run(M_PUSH, 8'h0, 8'hAB, 8'h0, 2'h0);
		acc(1'b0, OFS_SP, 32'h0);
		`CHK(q[7:0], 8'h08)
		acc(1'b0, ra(8'h08), 32'h0);
		`CHK(q[7:0], 8'hAB)
		run(M_POP, 8'h0, 8'h0, 8'h0, 2'h0);
		`CHK({q[31:24], q[15:0]}, 24'hAB_0008)
		acc(1'b0, OFS_SP, 32'h0);
		`CHK(q[7:0], 8'h07)
		$display("stack done");
		run(M_XDP, 8'h0, 8'h0, 8'h0, 2'h0);
		`CHK(xdata_addr, 16'hBEEF)
		acc(1'b1, OFS_PAGE, 32'h12);
		acc(1'b1, ra(8'h00), 32'h34);
		run(M_XRI, 8'h00, 8'h0, 8'h0, 2'h0);
		`CHK(xdata_addr, 16'h1234)
		acc(1'b1, OFS_PSEL, 32'h0);
		acc(1'b1, OFS_DP0, 32'h0F0F);
		run(M_XDP, 8'h0, 8'h0, 8'h0, 2'h0);
		`CHK(xdata_addr, 16'h0F0F)
		`CHK(n_xmv, 3)
		run(M_IMM, 8'h0, 8'h40, 8'h99, 2'h0);
		`CHK(q[31:24], 8'h40)
		acc(1'b1, OFS_ACC, 32'hF5);
		run(M_TDP, 8'h0, 8'h0, 8'h0, 2'h0);
		`CHK(code_addr, 16'h1004)
		acc(1'b0, OFS_ACC, 32'h0);
		`CHK(q[7:0], 8'h10 ^ 8'h04 ^ 8'hA5)
		acc(1'b1, OFS_PC, 32'hFFF0);
		acc(1'b1, OFS_ACC, 32'h20);
		run(M_TPC, 8'h0, 8'h0, 8'h0, 2'h0);
		`CHK(code_addr, 16'h0010)
		acc(1'b0, OFS_ACC, 32'h0);
		`CHK(q[7:0], 8'h10 ^ 8'hA5)
		`CHK(n_fetch, 2)
		$display("external and table done");
		br(16'h1010, M_REL, 8'h0, 8'h20, 8'h0, 2'h2, 16'h1032);
		br(16'h2359, M_REL, 8'h0, 8'hFE, 8'h0, 2'h2, 16'h2359);
		br(16'h0100, M_REL, 8'h0, 8'h7F, 8'h80, 2'h3, 16'h0083);
		br(16'h0100, M_REL, 8'h0, 8'h80, 8'h7F, 2'h3, 16'h0182);
		br(16'h7FFF, M_ABS, 8'h40, 8'h00, 8'h0, 2'h2, 16'h8200);
		br(16'h07FE, M_ABS, 8'hE1, 8'h34, 8'h0, 2'h2, 16'h0F34);
		br(16'h1234, M_LONG, 8'h0, 8'h80, 8'h00, 2'h3, 16'h8000);
		$display("branches done");
		acc(1'b1, OFS_SP, 32'h55);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		acc(1'b0, OFS_SP, 32'h0);
		`CHK(q, 32'h0000_0007)
		acc(1'b0, OFS_ACC, 32'h0);
		`CHK(q, 32'h0000_0000)
		$display("second reset done");
		results();
	end
endmodule
